// ### isc_top.sv
// Notes on behaviour
// RULE1: Watchdog NMI wins over every maskable request and ignores mask levels.
// RULE2: NMI held off after reset until both unlock addresses are written.
// RULE3: Each of 19 factors has a flag latched on its event until cleared.
// RULE4: Per-factor enable bit, 1 passes the request, 0 blocks it.
// RULE5: Request needs flag, enable and system level above CPU mask level.
// RULE6: Requests are sampled at the first opcode fetch of each instruction.
// RULE7: Halt stops CPU while peripherals and interrupt sources keep running.
// RULE8: Halt ends on reset or any interrupt request, CPU resumes.
// RULE9: Sleep stops CPU and both oscillators.
// RULE10: Sleep ends only on reset, NMI or input port request; oscillators restart.
// RULE11: Port 1 bits set flags D4-D7 on mismatch; priority at D6-D7.
// RULE12: Port 0 sets flag D3 on 8-bit mismatch; priority at D4-D5.
// RULE13: 16-bit timers flag underflow/match at D3-D6; priorities D0-D3.
// RULE14: 8-bit timer underflow flag at D7; priority at D6-D7 second register.
// RULE15: Serial error, receive, transmit flags at D0-D2; priority D4-D5.
// RULE16: LCD transfer done flag at D2; priority at D0-D1.
// RULE17: Clock timer flags D3-D7 on tick falling edges and minute overflow.
// RULE18: Writing 1 clears a flag, 0 leaves it; set flag keeps requesting.
// RULE19: Levels 0 to 3, 0 none; ties broken by fixed system order.
// RULE20: Reset clears all flags, enables and priority fields.
// RULE21: One-cycle event strobes set flags; set wins over same-cycle clear.
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none
module isc_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [isc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output var  logic                       awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output var  logic                       wready,
  output var  logic [1:0]                 bresp,
  output var  logic                       bvalid,
  input  wire logic                       bready,
  input  wire logic [isc_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output var  logic                       arready,
  output var  logic [31:0]                rdata,
  output var  logic [1:0]                 rresp,
  output var  logic                       rvalid,
  input  wire logic                       rready,
  input  wire logic [3:0]                 port1_in,
  input  wire logic [3:0]                 port1_compare_bits,
  input  wire logic [7:0]                 port0_in,
  input  wire logic [7:0]                 port0_compare_reg,
  input  wire logic                       timer0_underflow_evt,
  input  wire logic                       timer0_match_evt,
  input  wire logic                       timer1_underflow_evt,
  input  wire logic                       timer1_match_evt,
  input  wire logic                       timer8_underflow_evt,
  input  wire logic                       serial_rx_error_evt,
  input  wire logic                       serial_rx_done_evt,
  input  wire logic                       serial_tx_done_evt,
  input  wire logic                       lcd_transfer_done_evt,
  input  wire logic [3:0]                 clock_tick_levels,
  input  wire logic                       minute_overflow_evt,
  input  wire logic                       watchdog_nmi_evt,
  input  wire logic                       cpu_level_mask_lo,
  input  wire logic                       cpu_level_mask_hi,
  input  wire logic                       cpu_first_fetch,
  input  wire logic                       halt_instruction,
  input  wire logic                       sleep_instruction,
  output var  logic                       nmi_take,
  output var  logic                       irq_take,
  output var  logic [1:0]                 irq_level,
  output var  logic [4:0]                 irq_factor,
  output var  logic                       cpu_run,
  output var  logic                       low_speed_oscillator_on,
  output var  logic                       high_speed_oscillator_on
);
  typedef struct packed {
    logic [7:0]                 prio_a, prio_b, en_a, en_b, en_c, pend_a, pend_b, pend_c;
    logic                       nmi_pend, unl0, unl1;
    isc_pkg::isc_mode_t         mode;
    logic                       cpu_run;
    logic                       osc_run;
    logic                       nmi_take;
    logic                       irq_take;
    logic [1:0]                 irq_level;
    logic [4:0]                 irq_factor;
    logic [3:0]                 p1_miss_q;
    logic                       p0_miss_q;
    logic [3:0]                 tick_q;
    logic                       aw_got;
    logic [isc_pkg::ADDR_W-1:0] awaddr_q;
    logic                       w_got;
    logic [7:0]                 wdata_q;
    logic                       wstrb_q;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [1:0]                 rresp;
    logic [7:0]                 rdata;
  } isc_state_t;

  localparam isc_state_t ST_RST = '{mode: isc_pkg::ISC_MODE_RUN, cpu_run: 1'b1,
                                    osc_run: 1'b1, default: '0};

  isc_state_t                    st_r;
  isc_state_t                    st_nxt;
  logic [isc_pkg::NFACT-1:0]     flag;
  logic [isc_pkg::NFACT-1:0]     enab;
  logic [isc_pkg::NFACT-1:0]     req;
  logic [isc_pkg::NSYS-1:0][1:0] sys_lvl;
  logic [1:0]                    cpu_mask;
  logic [1:0]                    best_lvl;
  logic [4:0]                    best_idx;
  logic                          found, port_req, nmi_ready, wr_fire;
  logic [7:0]                    set_a, set_b, set_c;
  logic [7:0]                    clr_a, clr_b, clr_c;
  logic [8:0]                    wr_look, rd_look;
  logic [3:0]                    p1_miss;
  logic                          p0_miss;

  // Register read mux
  function automatic logic [8:0] rd_mux(input logic [isc_pkg::ADDR_W-1:0] a,
                                        input isc_state_t s);
    logic [isc_pkg::IDX_W-1:0] w;
    logic [8:0]                r;
    w = a[isc_pkg::IDX_W+1:2];
    r = {1'b1, 8'h00};
    if (a[1:0] == isc_pkg::WORD_ALIGN) begin
      case (w)
        isc_pkg::IDX_NMI_OPEN0: r = {1'b0, 8'h00};
        isc_pkg::IDX_NMI_OPEN1: r = {1'b0, 8'h00};
        isc_pkg::IDX_PRIO_A:    r = {1'b0, s.prio_a};
        isc_pkg::IDX_PRIO_B:    r = {1'b0, s.prio_b};
        isc_pkg::IDX_EN_A:      r = {1'b0, s.en_a};
        isc_pkg::IDX_EN_B:      r = {1'b0, s.en_b};
        isc_pkg::IDX_EN_C:      r = {1'b0, s.en_c};
        isc_pkg::IDX_PEND_A:    r = {1'b0, s.pend_a};
        isc_pkg::IDX_PEND_B:    r = {1'b0, s.pend_b};
        isc_pkg::IDX_PEND_C:    r = {1'b0, s.pend_c};
        default:                r = {1'b1, 8'h00};
      endcase
    end
    return r;
  endfunction : rd_mux

  always_comb begin
    cpu_mask = {cpu_level_mask_hi, cpu_level_mask_lo};
    wr_look = rd_mux(st_r.awaddr_q, st_r);
    rd_look = rd_mux(araddr, st_r);
    // RULE11: port 1 mismatch edges
    p1_miss = port1_in ^ port1_compare_bits;
    // RULE12: port 0 mismatch edge
    p0_miss = |(port0_in ^ port0_compare_reg);
    set_a = '0;
    set_a[isc_pkg::BIT_K1_LSB +: 4] = p1_miss & ~st_r.p1_miss_q;
    set_a[isc_pkg::BIT_K0] = p0_miss & ~st_r.p0_miss_q;
    // RULE13: 16-bit timer strobes
    set_b = '0;
    set_b[isc_pkg::BIT_TU0] = timer0_underflow_evt;
    set_b[isc_pkg::BIT_TC0] = timer0_match_evt;
    set_b[isc_pkg::BIT_TU1] = timer1_underflow_evt;
    set_b[isc_pkg::BIT_TC1] = timer1_match_evt;
    // RULE14: 8-bit timer strobe
    set_b[isc_pkg::BIT_TU2] = timer8_underflow_evt;
    // RULE15: serial strobes
    set_b[isc_pkg::BIT_SERR] = serial_rx_error_evt;
    set_b[isc_pkg::BIT_SRX] = serial_rx_done_evt;
    set_b[isc_pkg::BIT_STX] = serial_tx_done_evt;
    set_c = '0;
    // RULE16: LCD strobe
    set_c[isc_pkg::BIT_LCD] = lcd_transfer_done_evt;
    // RULE17: tick falling edges and minute overflow
    set_c[isc_pkg::BIT_CT_LSB +: 4] = st_r.tick_q & ~clock_tick_levels;
    set_c[isc_pkg::BIT_MIN] = minute_overflow_evt;

    // Factors in fixed default order
    flag = {st_r.pend_c[7:2], st_r.pend_b[2:0], st_r.pend_b[7:3], st_r.pend_a[3],
            st_r.pend_a[7:4]};
    enab = {st_r.en_c[7:2], st_r.en_b[2:0], st_r.en_b[7:3], st_r.en_a[3], st_r.en_a[7:4]};
    sys_lvl[0] = st_r.prio_a[isc_pkg::PRI_K1 +: 2];
    sys_lvl[1] = st_r.prio_a[isc_pkg::PRI_K0 +: 2];
    sys_lvl[2] = st_r.prio_a[isc_pkg::PRI_TM0 +: 2];
    sys_lvl[3] = st_r.prio_a[isc_pkg::PRI_TM1 +: 2];
    sys_lvl[4] = st_r.prio_b[isc_pkg::PRI_TM8 +: 2];
    sys_lvl[5] = st_r.prio_b[isc_pkg::PRI_SER +: 2];
    sys_lvl[6] = st_r.prio_b[isc_pkg::PRI_LCD +: 2];
    sys_lvl[7] = st_r.prio_b[isc_pkg::PRI_CT +: 2];
    best_lvl = isc_pkg::LVL_NONE;
    best_idx = '0;
    found = 1'b0;
    for (int i = isc_pkg::NFACT - 1; i >= 0; i--) begin
      // RULE4: enable gate
      // RULE5: level above CPU mask
      req[i] = flag[i] & enab[i] & (sys_lvl[isc_pkg::FACT_SYS[i]] > cpu_mask);
      // RULE19: highest level, earlier factor wins ties
      if (req[i] && (sys_lvl[isc_pkg::FACT_SYS[i]] >= best_lvl)) begin
        best_lvl = sys_lvl[isc_pkg::FACT_SYS[i]];
        best_idx = 5'(i);
        found = 1'b1;
      end
    end
    port_req = |req[isc_pkg::NPORT_FACT-1:0];
    // RULE2: NMI passes only after both unlock writes
    nmi_ready = st_r.nmi_pend & st_r.unl0 & st_r.unl1;

    st_nxt = st_r;
    st_nxt.nmi_take = 1'b0;
    st_nxt.irq_take = 1'b0;
    st_nxt.p1_miss_q = p1_miss;
    st_nxt.p0_miss_q = p0_miss;
    st_nxt.tick_q = clock_tick_levels;

    // Write channel capture
    if (awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr_q = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata_q = wdata[7:0];
      st_nxt.wstrb_q = wstrb[0];
    end
    if (bready && st_r.bvalid) begin
      st_nxt.bvalid = 1'b0;
    end
    clr_a = '0;
    clr_b = '0;
    clr_c = '0;
    wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_look[8] ? isc_pkg::RESP_SLVERR : isc_pkg::RESP_OKAY;
      if (st_r.wstrb_q && st_r.awaddr_q[1:0] == isc_pkg::WORD_ALIGN) begin
        case (st_r.awaddr_q[isc_pkg::IDX_W+1:2])
          // RULE2: unlock writes
          isc_pkg::IDX_NMI_OPEN0: st_nxt.unl0 = 1'b1;
          isc_pkg::IDX_NMI_OPEN1: st_nxt.unl1 = 1'b1;
          isc_pkg::IDX_PRIO_A:    st_nxt.prio_a = st_r.wdata_q;
          isc_pkg::IDX_PRIO_B:    st_nxt.prio_b = st_r.wdata_q;
          isc_pkg::IDX_EN_A:      st_nxt.en_a = st_r.wdata_q & isc_pkg::MASK_A;
          isc_pkg::IDX_EN_B:      st_nxt.en_b = st_r.wdata_q & isc_pkg::MASK_B;
          isc_pkg::IDX_EN_C:      st_nxt.en_c = st_r.wdata_q & isc_pkg::MASK_C;
          // RULE18: write one to clear
          isc_pkg::IDX_PEND_A:    clr_a = st_r.wdata_q;
          isc_pkg::IDX_PEND_B:    clr_b = st_r.wdata_q;
          isc_pkg::IDX_PEND_C:    clr_c = st_r.wdata_q;
          default:                clr_a = '0;
        endcase
      end
    end
    st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
    st_nxt.wready = ~st_nxt.w_got & ~st_nxt.bvalid;

    // Read channel
    if (rready && st_r.rvalid) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_look[7:0];
      st_nxt.rresp = rd_look[8] ? isc_pkg::RESP_SLVERR : isc_pkg::RESP_OKAY;
    end
    st_nxt.arready = ~st_nxt.rvalid;

    // RULE3: flags latch until cleared
    // RULE21: set wins over clear
    st_nxt.pend_a = ((st_r.pend_a & ~clr_a) | set_a) & isc_pkg::MASK_A;
    st_nxt.pend_b = ((st_r.pend_b & ~clr_b) | set_b) & isc_pkg::MASK_B;
    st_nxt.pend_c = ((st_r.pend_c & ~clr_c) | set_c) & isc_pkg::MASK_C;

    // RULE6: sample at first opcode fetch
    if (cpu_first_fetch && st_r.cpu_run) begin
      // RULE1: NMI before maskable requests
      if (nmi_ready) begin
        st_nxt.nmi_take = 1'b1;
        st_nxt.nmi_pend = 1'b0;
      end else if (found) begin
        st_nxt.irq_take = 1'b1;
        st_nxt.irq_level = best_lvl;
        st_nxt.irq_factor = best_idx;
      end
    end
    if (watchdog_nmi_evt) begin
      st_nxt.nmi_pend = 1'b1;
    end

    case (st_r.mode)
      isc_pkg::ISC_MODE_RUN: begin
        // RULE9: sleep stops CPU and oscillators
        if (sleep_instruction) begin
          st_nxt.mode = isc_pkg::ISC_MODE_SLEEP;
          st_nxt.cpu_run = 1'b0;
          st_nxt.osc_run = 1'b0;
        // RULE7: halt stops only the CPU
        end else if (halt_instruction) begin
          st_nxt.mode = isc_pkg::ISC_MODE_HALT;
          st_nxt.cpu_run = 1'b0;
        end
      end
      isc_pkg::ISC_MODE_HALT: begin
        // RULE8: any request wakes halt
        if (nmi_ready || found) begin
          st_nxt.mode = isc_pkg::ISC_MODE_RUN;
          st_nxt.cpu_run = 1'b1;
        end
      end
      isc_pkg::ISC_MODE_SLEEP: begin
        // RULE10: only NMI or port request wakes sleep
        if (nmi_ready || port_req) begin
          st_nxt.mode = isc_pkg::ISC_MODE_RUN;
          st_nxt.cpu_run = 1'b1;
          st_nxt.osc_run = 1'b1;
        end
      end
      default: begin
        st_nxt.mode = isc_pkg::ISC_MODE_RUN;
        st_nxt.cpu_run = 1'b1;
        st_nxt.osc_run = 1'b1;
      end
    endcase
  end

  // RULE20: reset clears flags, enables, levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rresp = st_r.rresp;
  assign rdata = {24'h000000, st_r.rdata};
  assign nmi_take = st_r.nmi_take;
  assign irq_take = st_r.irq_take;
  assign irq_level = st_r.irq_level;
  assign irq_factor = st_r.irq_factor;
  assign cpu_run = st_r.cpu_run;
  assign low_speed_oscillator_on = st_r.osc_run;
  assign high_speed_oscillator_on = st_r.osc_run;

  property p_nmi_first;
    @(posedge aclk) disable iff (!aresetn)
    (cpu_first_fetch && st_r.cpu_run && nmi_ready) |=> (nmi_take && !irq_take);
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("NMI lost to maskable"); // RULE1
  property p_nmi_locked;
    @(posedge aclk) disable iff (!aresetn)
    !(st_r.unl0 && st_r.unl1) |=> !nmi_take;
  endproperty
  a_nmi_locked: assert property (p_nmi_locked) else $error("NMI passed while locked"); // RULE2
  property p_flag_hold;
    @(posedge aclk) disable iff (!aresetn)
    !wr_fire |=> ((st_r.pend_b & $past(st_r.pend_b)) == $past(st_r.pend_b));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Flag dropped without write"); // RULE3
  property p_set_wins;
    @(posedge aclk) disable iff (!aresetn)
    timer0_underflow_evt |=> st_r.pend_b[isc_pkg::BIT_TU0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Event strobe not latched"); // RULE21
  property p_no_req_no_take;
    @(posedge aclk) disable iff (!aresetn)
    (cpu_first_fetch && !found && !nmi_ready) |=> !irq_take && !nmi_take;
  endproperty
  a_no_req_no_take: assert property (p_no_req_no_take) else $error("Take without request"); // RULE4
  property p_level_above;
    @(posedge aclk) disable iff (!aresetn)
    irq_take |-> (irq_level > $past({cpu_level_mask_hi, cpu_level_mask_lo}));
  endproperty
  a_level_above: assert property (p_level_above) else $error("Level not above mask"); // RULE5
  property p_halt;
    @(posedge aclk) disable iff (!aresetn)
    (st_r.mode == isc_pkg::ISC_MODE_RUN && halt_instruction && !sleep_instruction)
      |=> !cpu_run && low_speed_oscillator_on ##1 (cpu_run == $past(found || nmi_ready));
  endproperty
  a_halt: assert property (p_halt) else $error("Halt entry or wake wrong"); // RULE7
  property p_sleep;
    @(posedge aclk) disable iff (!aresetn)
    (st_r.mode == isc_pkg::ISC_MODE_RUN && sleep_instruction)
      |=> !cpu_run && !low_speed_oscillator_on && !high_speed_oscillator_on;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep entry wrong"); // RULE9
  property p_sleep_wake;
    @(posedge aclk) disable iff (!aresetn)
    (st_r.mode == isc_pkg::ISC_MODE_SLEEP) |=> (cpu_run == $past(port_req || nmi_ready));
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("Sleep wake wrong"); // RULE10
endmodule : isc_top
`default_nettype wire

// ### isc_pkg.sv
`default_nettype none
package isc_pkg;
  localparam int ADDR_W = 18;
  localparam int IDX_W  = 16;
  localparam int NFACT  = 19;
  localparam int NSYS   = 8;
  // Register indexes, byte address is four times the index
  localparam logic [15:0] IDX_NMI_OPEN0 = 16'hFF00;
  localparam logic [15:0] IDX_NMI_OPEN1 = 16'hFF01;
  localparam logic [15:0] IDX_PRIO_A    = 16'hFF20;
  localparam logic [15:0] IDX_PRIO_B    = 16'hFF21;
  localparam logic [15:0] IDX_EN_A      = 16'hFF23;
  localparam logic [15:0] IDX_EN_B      = 16'hFF24;
  localparam logic [15:0] IDX_EN_C      = 16'hFF25;
  localparam logic [15:0] IDX_PEND_A    = 16'hFF27;
  localparam logic [15:0] IDX_PEND_B    = 16'hFF28;
  localparam logic [15:0] IDX_PEND_C    = 16'hFF29;
  localparam logic [7:0]  REG_RST       = 8'h00;
  localparam logic [7:0]  MASK_A        = 8'hF8;
  localparam logic [7:0]  MASK_B        = 8'hFF;
  localparam logic [7:0]  MASK_C        = 8'hFC;
  localparam logic [1:0]  WORD_ALIGN    = 2'h0;
  // Flag and enable bit positions
  localparam int BIT_K1_LSB = 4;
  localparam int BIT_K0     = 3;
  localparam int BIT_TU0    = 3;
  localparam int BIT_TC0    = 4;
  localparam int BIT_TU1    = 5;
  localparam int BIT_TC1    = 6;
  localparam int BIT_TU2    = 7;
  localparam int BIT_SERR   = 0;
  localparam int BIT_SRX    = 1;
  localparam int BIT_STX    = 2;
  localparam int BIT_LCD    = 2;
  localparam int BIT_CT_LSB = 3;
  localparam int BIT_MIN    = 7;
  // Priority field positions, first four in A, last four in B
  localparam int PRI_K1  = 6;
  localparam int PRI_K0  = 4;
  localparam int PRI_TM0 = 0;
  localparam int PRI_TM1 = 2;
  localparam int PRI_TM8 = 6;
  localparam int PRI_SER = 4;
  localparam int PRI_LCD = 0;
  localparam int PRI_CT  = 2;
  // System of each factor, factor 0 first in fixed order
  localparam logic [18:0][2:0] FACT_SYS = {3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h6, 3'h5, 3'h5,
                                           3'h5, 3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h1, 3'h0,
                                           3'h0, 3'h0, 3'h0};
  localparam int NPORT_FACT = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] LVL_NONE    = 2'h0;
  typedef enum logic [1:0] {
    ISC_MODE_RUN   = 2'b00,
    ISC_MODE_HALT  = 2'b01,
    ISC_MODE_SLEEP = 2'b10
  } isc_mode_t;
endpackage : isc_pkg
`default_nettype wire

// ### isc_src_model.sv
`default_nettype none
module isc_src_model (
  input  wire logic        aclk,
  input  wire logic        fire,
  input  wire logic [4:0]  sel,
  output var  logic [19:0] ev
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge aclk) begin
    ev <= fire ? (20'h00001 << sel) : 20'h00000;
  end
endmodule : isc_src_model
`default_nettype wire

// ### test_interrupt_and_standby_control.sv
`default_nettype none
module test_interrupt_and_standby_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = isc_pkg::RESP_OKAY;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire;
  logic        awready, wready, bvalid, arready, rvalid, nmi_take, irq_take, cpu_run;
  logic        cpu_level_mask_lo, cpu_level_mask_hi, cpu_first_fetch;
  logic        halt_instruction, sleep_instruction;
  logic        low_speed_oscillator_on, high_speed_oscillator_on;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, irq_level;
  logic [4:0]  irq_factor, sel;
  logic [19:0] ev;
  int          errors, n_checks;

  isc_src_model src (.aclk, .fire, .sel, .ev);
  isc_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .port1_in(ev[3:0]), .port1_compare_bits(4'h0),
    .port0_in({7'h00, ev[4]}), .port0_compare_reg(8'h00), .timer0_underflow_evt(ev[5]),
    .timer0_match_evt(ev[6]), .timer1_underflow_evt(ev[7]), .timer1_match_evt(ev[8]),
    .timer8_underflow_evt(ev[9]), .serial_rx_error_evt(ev[10]),
    .serial_rx_done_evt(ev[11]), .serial_tx_done_evt(ev[12]),
    .lcd_transfer_done_evt(ev[13]), .clock_tick_levels(~ev[17:14]),
    .minute_overflow_evt(ev[18]), .watchdog_nmi_evt(ev[19]), .cpu_level_mask_lo,
    .cpu_level_mask_hi, .cpu_first_fetch, .halt_instruction, .sleep_instruction,
    .nmi_take, .irq_take, .irq_level, .irq_factor, .cpu_run, .low_speed_oscillator_on,
    .high_speed_oscillator_on);

  task automatic tally_and_finish;
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] ix, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {ix, 2'h0};
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid || !bvalid);
    chk("bresp", er, bresp);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] ix, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {ix, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (arvalid || !rvalid);
    chk("rdata", {24'h000000, d}, rdata);
    chk("rresp", er, rresp);
    rready <= 1'b0;
  endtask : rd

  task automatic fr(input logic [4:0] f);
    @(posedge aclk);
    fire <= 1'b1;
    sel <= f;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (2) @(posedge aclk);
    @(posedge aclk);
  endtask : fr

  task automatic ft(input logic nm, input logic iq, input logic [1:0] lv,
                    input logic [4:0] fc);
    @(posedge aclk);
    cpu_first_fetch <= 1'b1;
    @(posedge aclk);
    cpu_first_fetch <= 1'b0;
    @(posedge aclk);
    chk("nmi_take", nm, nmi_take);
    chk("irq_take", iq, irq_take);
    if (iq) chk("irq_level", lv, irq_level);
    if (iq) chk("irq_factor", fc, irq_factor);
  endtask : ft

  task automatic sb(input logic s);
    @(posedge aclk);
    sleep_instruction <= s;
    halt_instruction <= !s;
    @(posedge aclk);
    sleep_instruction <= 1'b0;
    halt_instruction <= 1'b0;
    repeat (2) @(posedge aclk);
    @(posedge aclk);
  endtask : sb

  function automatic logic [18:0] loc(input int f);
    if (f < 4) return {isc_pkg::IDX_PEND_A, 3'(f + 4)};
    if (f == 4) return {isc_pkg::IDX_PEND_A, 3'h3};
    if (f < 10) return {isc_pkg::IDX_PEND_B, 3'(f - 2)};
    if (f < 13) return {isc_pkg::IDX_PEND_B, 3'(f - 10)};
    if (f == 13) return {isc_pkg::IDX_PEND_C, 3'h2};
    return {isc_pkg::IDX_PEND_C, 3'(f - 11)};
  endfunction : loc

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    tally_and_finish();
  end

  initial begin
    logic [18:0] l;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fire, sel} = '0;
    {cpu_level_mask_lo, cpu_level_mask_hi, cpu_first_fetch} = '0;
    {halt_instruction, sleep_instruction, awaddr, araddr, wdata, wstrb} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++)
      rd(isc_pkg::IDX_PRIO_A + 16'(i), 8'h00,
         (i == 2 || i == 6) ? isc_pkg::RESP_SLVERR : OK);
    wr(isc_pkg::IDX_EN_A, 8'hFF, OK);
    rd(isc_pkg::IDX_EN_A, isc_pkg::MASK_A, OK);
    wr(isc_pkg::IDX_EN_A, 8'h00, OK);
    for (int f = 0; f < 19; f++) begin
      l = loc(f);
      fr(5'(f));
      rd(l[18:3], 8'h01 << l[2:0], OK);
      wr(l[18:3], 8'h00, OK);
      rd(l[18:3], 8'h01 << l[2:0], OK);
      wr(l[18:3], 8'h01 << l[2:0], OK);
      rd(l[18:3], 8'h00, OK);
    end
    wr(isc_pkg::IDX_PRIO_A, 8'h02, OK);
    wr(isc_pkg::IDX_PRIO_B, 8'h20, OK);
    wr(isc_pkg::IDX_EN_B, 8'h09, OK);
    fr(5'h0A);
    fr(5'h05);
    ft(1'b0, 1'b1, 2'h2, 5'h05);
    wr(isc_pkg::IDX_PRIO_B, 8'h30, OK);
    ft(1'b0, 1'b1, 2'h3, 5'h0A);
    cpu_level_mask_hi <= 1'b1;
    cpu_level_mask_lo <= 1'b1;
    ft(1'b0, 1'b0, 2'h0, 5'h00);
    cpu_level_mask_lo <= 1'b0;
    ft(1'b0, 1'b1, 2'h3, 5'h0A);
    wr(isc_pkg::IDX_PRIO_B, 8'h20, OK);
    ft(1'b0, 1'b0, 2'h0, 5'h00);
    cpu_level_mask_hi <= 1'b0;
    wr(isc_pkg::IDX_EN_B, 8'h00, OK);
    ft(1'b0, 1'b0, 2'h0, 5'h00);
    wr(isc_pkg::IDX_EN_B, 8'h09, OK);
    fr(5'h13);
    ft(1'b0, 1'b1, 2'h2, 5'h05);
    wr(isc_pkg::IDX_NMI_OPEN0, 8'h00, OK);
    ft(1'b0, 1'b1, 2'h2, 5'h05);
    wr(isc_pkg::IDX_NMI_OPEN1, 8'h00, OK);
    ft(1'b1, 1'b0, 2'h0, 5'h00);
    {cpu_level_mask_hi, cpu_level_mask_lo} <= 2'h3;
    fr(5'h13);
    ft(1'b1, 1'b0, 2'h0, 5'h00);
    {cpu_level_mask_hi, cpu_level_mask_lo} <= 2'h0;
    wr(isc_pkg::IDX_PEND_B, 8'hFF, OK);
    sb(1'b0);
    chk("cpu_run", 1'b0, cpu_run);
    fr(5'h05);
    chk("cpu_run", 1'b1, cpu_run);
    rd(isc_pkg::IDX_PEND_B, 8'h08, OK);
    wr(isc_pkg::IDX_PEND_B, 8'hFF, OK);
    wr(isc_pkg::IDX_PRIO_A, 8'h42, OK);
    wr(isc_pkg::IDX_EN_A, 8'h10, OK);
    sb(1'b1);
    chk("osc", 2'h0, {low_speed_oscillator_on, high_speed_oscillator_on});
    fr(5'h05);
    chk("cpu_run", 1'b0, cpu_run);
    fr(5'h00);
    chk("cpu_run", 1'b1, cpu_run);
    chk("osc", 2'h3, {low_speed_oscillator_on, high_speed_oscillator_on});
    tally_and_finish();
  end
endmodule : test_interrupt_and_standby_control
`default_nettype wire
